/* design/core_ops.sv */
`timescale 1ns/10ps
`include "core_ops_defines.svh"
module core_ops (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // program fetch
  input wire logic [15:0] instr,
  input wire logic instr_second_word,
  input wire logic ext_set_en,
  output logic [20:0] pc_q,
  output logic fetch_q,
  // data memory
  output logic [11:0] rd_addr_q,
  input wire logic [7:0] rd_data,
  output core_ops_pkg::file_wr_t file_wr_q,
  // core state
  input wire logic [3:0] bank_select_reg,
  input wire logic [11:0] fsr2,
  output logic [7:0] acc_q,
  output core_ops_pkg::flags_t flags_q
);
  logic [3:0] phase;
  quarter_phase_gen u_phase (
    .clock(clock),
    .sys_rst(sys_rst),
    .phase_q(phase)
  );

  function automatic logic [11:0] file_addr(input logic [15:0] iw, input logic [3:0] bank,
      input logic [11:0] base, input logic ext);
    logic [7:0] f;
    f = iw[7:0];
    if (!iw[`F_ACC_BIT] && ext && f <= `IDX_LIMIT) begin
      file_addr = base + {4'h0, f};
    end else if (!iw[`F_ACC_BIT]) begin
      file_addr = (f < 8'h60) ? {4'h0, f} : {4'hF, f};
    end else begin
      file_addr = {bank, f};
    end
  endfunction : file_addr

  function automatic logic [7:0] nz_flags_src(input logic [7:0] r);
    nz_flags_src = r;
  endfunction : nz_flags_src

  // decode, held for the instruction cycle
  core_ops_pkg::op_t op_q;
  logic [15:0] ir_q;
  logic [7:0] opnd_q;
  logic [7:0] res_q;
  core_ops_pkg::flags_t nf_q;

  wire [15:0] ir_sel = instr;
  wire is_addc = ir_sel[15:10] == `OP_ADDC_HI6;
  wire is_andf = ir_sel[15:10] == `OP_ANDF_HI6;
  wire is_andi = ir_sel[15:8] == `OP_ANDI_HI8;
  wire is_brc = ir_sel[15:8] == `OP_BRC_HI8;
  wire is_bclr = ir_sel[15:12] == `OP_BCLR_HI4;
  core_ops_pkg::op_t op_dec;
  assign op_dec = instr_second_word ? core_ops_pkg::OP_NONE :
                  is_addc ? core_ops_pkg::OP_ADDC :
                  is_andf ? core_ops_pkg::OP_ANDF :
                  is_andi ? core_ops_pkg::OP_ANDI :
                  is_brc ? core_ops_pkg::OP_BRC :
                  is_bclr ? core_ops_pkg::OP_BCLR : core_ops_pkg::OP_NONE;

  // arithmetic
  wire [8:0] sum9 = {1'b0, acc_q} + {1'b0, opnd_q} + {8'h00, flags_q.c};
  wire [4:0] sum_lo = {1'b0, acc_q[3:0]} + {1'b0, opnd_q[3:0]} + {4'h0, flags_q.c};
  wire sum_ov = (acc_q[7] == opnd_q[7]) && (sum9[7] != acc_q[7]);
  wire [7:0] and_r = acc_q & opnd_q;
  wire [7:0] bclr_r = opnd_q & ~(8'h01 << ir_q[`F_BSEL_LSB +: 3]);
  wire carry_taken = flags_q.c;
  wire [20:0] br_off = {{12{ir_q[7]}}, ir_q[7:0], 1'b0};
  wire dest_file = ir_q[`F_DEST_BIT];

  logic [7:0] res_d;
  core_ops_pkg::flags_t nf_d;
  always_comb begin
    res_d = 8'h00;
    nf_d = flags_q;
    case (op_q)
      core_ops_pkg::OP_ADDC: begin
        res_d = sum9[7:0];
        nf_d.c = sum9[8];
        nf_d.dc = sum_lo[4];
        nf_d.ov = sum_ov;
        nf_d.n = sum9[7];
        nf_d.z = sum9[7:0] == 8'h00;
      end
      core_ops_pkg::OP_ANDI, core_ops_pkg::OP_ANDF: begin
        res_d = and_r;
        nf_d.n = and_r[7];
        nf_d.z = nz_flags_src(and_r) == 8'h00;
      end
      core_ops_pkg::OP_BCLR: begin
        res_d = bclr_r;
      end
      default: begin
        res_d = 8'h00;
      end
    endcase
  end

  logic skip_q;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      op_q <= core_ops_pkg::OP_NONE;
      ir_q <= 16'h0000;
      skip_q <= 1'b0;
      rd_addr_q <= 12'h000;
    end else if (phase[0]) begin
      op_q <= skip_q ? core_ops_pkg::OP_NONE : op_dec;
      skip_q <= 1'b0;
      ir_q <= instr;
      rd_addr_q <= file_addr(instr, bank_select_reg, fsr2, ext_set_en);
    end else if (phase[3] && op_q == core_ops_pkg::OP_BRC && carry_taken) begin
      skip_q <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      opnd_q <= 8'h00;
      res_q <= 8'h00;
      nf_q <= `RST_FLAGS;
    end else if (phase[1]) begin
      opnd_q <= (op_q == core_ops_pkg::OP_ANDI) ? ir_q[7:0] : rd_data;
    end else if (phase[2]) begin
      res_q <= res_d;
      nf_q <= nf_d;
    end
  end

  wire writes_acc = (op_q == core_ops_pkg::OP_ANDI) ||
                    ((op_q == core_ops_pkg::OP_ADDC || op_q == core_ops_pkg::OP_ANDF) && !dest_file);
  wire writes_file = op_q == core_ops_pkg::OP_BCLR ||
                     ((op_q == core_ops_pkg::OP_ADDC || op_q == core_ops_pkg::OP_ANDF) && dest_file);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      acc_q <= `RST_ACC;
      flags_q <= `RST_FLAGS;
      pc_q <= `RST_PC;
      fetch_q <= 1'b0;
      file_wr_q <= '0;
    end else begin
      fetch_q <= 1'b0;
      file_wr_q.we <= 1'b0;
      if (phase[3]) begin
        if (writes_acc) begin
          acc_q <= res_q;
        end
        if (writes_file) begin
          file_wr_q.we <= 1'b1;
          file_wr_q.addr <= rd_addr_q;
          file_wr_q.data <= res_q;
        end
        flags_q <= nf_q;
        if (op_q == core_ops_pkg::OP_BRC && carry_taken) begin
          pc_q <= pc_q + 21'h000002 + br_off;
        end else begin
          pc_q <= pc_q + 21'h000002;
        end
        fetch_q <= 1'b1;
      end
    end
  end
endmodule : core_ops

/* design/core_ops_defines.svh */
`ifndef CORE_OPS_DEFINES_SVH
`define CORE_OPS_DEFINES_SVH
// opcode matches on the upper instruction bits
`define OP_ADDC_HI6 6'h08
`define OP_ANDF_HI6 6'h05
`define OP_ANDI_HI8 8'h0B
`define OP_BRC_HI8 8'hE2
`define OP_BCLR_HI4 4'h9
// field positions
`define F_DEST_BIT 9
`define F_ACC_BIT 8
`define F_BSEL_LSB 9
// indexed literal offset limit
`define IDX_LIMIT 8'h5F
// status flag positions
`define FLG_C 0
`define FLG_DC 1
`define FLG_Z 2
`define FLG_OV 3
`define FLG_N 4
// reset values
`define RST_ACC 8'h00
`define RST_FLAGS 5'h00
`define RST_PC 21'h000000
`define RST_BANK 4'h0
`define RST_FSR2 12'h000
// timing: quarter phases per instruction cycle
`define QPHASES 4
`define NOP_CYCLES 1
`endif

/* design/core_ops_pkg.sv */
package core_ops_pkg;
  typedef enum logic [2:0] {OP_NONE, OP_ADDC, OP_ANDI, OP_ANDF, OP_BRC, OP_BCLR} op_t;
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] data;
    logic we;
  } file_wr_t;
  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } flags_t;
endpackage : core_ops_pkg

/* design/quarter_phase_gen.sv */
`timescale 1ns/10ps
`include "core_ops_defines.svh"
// four quarter-phase enables, one high per clock
module quarter_phase_gen (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // phase enables
  output logic [3:0] phase_q
);
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      phase_q <= 4'h1;
    end else begin
      phase_q <= {phase_q[2:0], phase_q[3]};
    end
  end
endmodule : quarter_phase_gen

/* verif/data_mem_model.sv */
`timescale 1ns/10ps
module data_mem_model (
  // clock
  input wire logic clock,
  // file port
  input wire logic [11:0] rd_addr_q,
  output logic [7:0] rd_data,
  input wire core_ops_pkg::file_wr_t file_wr_q
);
  logic [7:0] mem [0:4095];
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 8'hC7;
    mem[12'h011] = 8'h81;
    mem[12'h012] = 8'h05;
  end
  assign rd_data = mem[rd_addr_q];
  always @(posedge clock) if (file_wr_q.we) mem[file_wr_q.addr] <= file_wr_q.data;
endmodule : data_mem_model

/* verif/core_ops_sva.sv */
`timescale 1ns/10ps
module core_ops_sva (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // watched ports
  input wire logic [15:0] instr,
  input wire logic instr_second_word,
  input wire logic [20:0] pc_q,
  input wire logic fetch_q,
  input wire logic [7:0] rd_data,
  input wire core_ops_pkg::file_wr_t file_wr_q,
  input wire logic [7:0] acc_q,
  input wire core_ops_pkg::flags_t flags_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // an instruction fetched behind a taken carry branch runs as a nop
  sequence q1(m);
    fetch_q && !instr_second_word && m &&
      !($past(fetch_q, 4) && !$past(instr_second_word, 4) && $past(instr[15:8], 4) == 8'hE2 && flags_q.c);
  endsequence
  fetch_gap_a: assert property (fetch_q |=> !fetch_q [*3]) else $error("fetch spacing");
  wr_pulse_a: assert property (file_wr_q.we |-> fetch_q ##1 !file_wr_q.we) else $error("write strobe");
  acc_hold_a: assert property ($changed(acc_q) |-> fetch_q) else $error("acc moved early");
  addc_sum_a: assert property (q1(instr[15:9] == 7'h10) |-> ##4
    acc_q == 8'($past(acc_q, 4) + $past(rd_data, 3) + $past(flags_q.c, 4))) else $error("add sum");
  andi_res_a: assert property (q1(instr[15:8] == 8'h0B) |-> ##4 acc_q == ($past(acc_q, 4) & $past(instr[7:0], 4))
    && flags_q.n == acc_q[7] && flags_q.z == !acc_q && flags_q.c == $past(flags_q.c, 4)) else $error("and");
  brc_pc_a: assert property (q1(instr[15:8] == 8'hE2) |-> ##4 flags_q == $past(flags_q, 4) && pc_q ==
    $past(pc_q, 4) + 21'h2 + ($past(flags_q.c, 4) ? 21'($signed($past(instr[7:0], 4))) << 1 : 21'h0)) else $error("branch");
  bclr_bit_a: assert property (q1(instr[15:12] == 4'h9) |-> ##4 file_wr_q.we && flags_q == $past(flags_q, 4)
    && file_wr_q.data == ($past(rd_data, 3) & ~(8'h01 << $past(instr[11:9], 4)))) else $error("bit clear");
  sec_nop_a: assert property (fetch_q && instr_second_word |-> ##4 acc_q == $past(acc_q, 4) && !file_wr_q.we)
    else $error("second word ran");
endmodule : core_ops_sva
bind core_ops core_ops_sva chk (.*);

/* verif/cpu_add_and_branch_bitclear_ops_tb.sv */
`timescale 1ns/10ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin errors++; $display("BAD %s %h %h", n, e, s); end end
module cpu_add_and_branch_bitclear_ops_tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] instr = 16'h0000;
  logic instr_second_word = 1'b0;
  logic ext_set_en = 1'b0;
  logic [3:0] bank_select_reg = 4'h2;
  logic [11:0] fsr2 = 12'h100;
  logic [20:0] pc_q;
  logic fetch_q;
  logic [11:0] rd_addr_q;
  logic [7:0] rd_data;
  core_ops_pkg::file_wr_t file_wr_q;
  logic [7:0] acc_q;
  core_ops_pkg::flags_t flags_q;
  int errors = 0;
  int comparisons = 0;
  always #10 clock = ~clock;
  core_ops DUT (.*);
  data_mem_model M (.*);
  task ex(input logic [15:0] w);
    instr = w;
    repeat (4) @(negedge clock);
  endtask : ex
  task t_add;
    ex(16'h2013);
    `CHK("acc", 8'hC7, acc_q)
    `CHK("flags", 5'h10, flags_q)
    ex(16'hE205);
    `CHK("pc", 21'h000004, pc_q)
    ex(16'h2011);
    `CHK("acc", 8'h48, acc_q)
    `CHK("flags", 5'h09, flags_q)
    $display("t_add done");
  endtask : t_add
  task t_and;
    ex(16'h1613);
    `CHK("wr", {12'h013, 8'h40, 1'b1}, file_wr_q)
    `CHK("acc", 8'h48, acc_q)
    ex(16'h0B80);
    `CHK("acc", 8'h00, acc_q)
    `CHK("flags", 5'h0D, flags_q)
    $display("t_and done");
  endtask : t_and
  task t_branch;
    ex(16'hE205);
    `CHK("pc", 21'h000016, pc_q)
    `CHK("flags", 5'h0D, flags_q)
    ex(16'h2013);
    `CHK("acc", 8'h00, acc_q)
    $display("t_branch done");
  endtask : t_branch
  task t_dest;
    ex(16'h2212);
    `CHK("wr", {12'h012, 8'h06, 1'b1}, file_wr_q)
    `CHK("flags", 5'h00, flags_q)
    instr_second_word = 1'b1;
    ex(16'h2013);
    instr_second_word = 1'b0;
    `CHK("acc", 8'h00, acc_q)
    $display("t_dest done");
  endtask : t_dest
  task t_bclr;
    ex(16'h9E14);
    `CHK("wr", {12'h014, 8'h47, 1'b1}, file_wr_q)
    ex(16'h9F14);
    `CHK("wr", {12'h214, 8'h47, 1'b1}, file_wr_q)
    ext_set_en = 1'b1;
    ex(16'h9005);
    `CHK("wr", {12'h105, 8'hC6, 1'b1}, file_wr_q)
    `CHK("flags", 5'h00, flags_q)
    $display("t_bclr done");
  endtask : t_bclr
  task tally_and_finish;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (16) @(negedge clock);
    sys_rst = 1'b0;
    t_add;
    t_and;
    t_branch;
    t_dest;
    t_bclr;
    tally_and_finish;
  end
endmodule : cpu_add_and_branch_bitclear_ops_tb
